// file: dv/semo_chk.sv
// Assertions on the encoder, index, monitor and select outputs.
`default_nettype none
module semo_chk #(
    parameter int INDEX_CYCLES = 20,
    parameter int MOTOR_CPR = 400
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic motor_step_i,
    input wire logic motor_dir_i,
    input wire logic data_select_bit0_i,
    input wire logic data_select_bit1_i,
    input wire logic data_select_bit2_i,
    input wire logic encoder_phase_a_out_o,
    input wire logic encoder_phase_b_out_o,
    input wire logic index_pulse_out_first_o,
    input wire logic index_pulse_out_second_o,
    input wire logic signed [15:0] speed_monitor_out_o,
    input wire logic signed [15:0] torque_monitor_out_o,
    input wire logic [2:0] limit_data_no_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic a, b, ix;
    logic [2:0] sel;
    assign a = encoder_phase_a_out_o;
    assign b = encoder_phase_b_out_o;
    assign ix = index_pulse_out_first_o;
    assign sel = {data_select_bit2_i, data_select_bit1_i, data_select_bit0_i};
    default clocking dcb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // Cycles the index pulse has stood, so the whole width is measured.
    int ix_len;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ix_len <= 0;
        end else begin
            ix_len <= ix ? ix_len + 1 : 0;
        end
    end
    property p_gray;
        !($changed(a) && $changed(b));
    endproperty
    a_gray: assert property (p_gray)
        else $error("phases moved together");
    // A forward quarter step leaves the phases unequal after an A change and equal after a B change; reverse is the opposite.
    property p_dir;
        ($changed(a) || $changed(b)) |->
            (a ^ b) == ($changed(a) ^ $past(motor_dir_i));
    endproperty
    a_dir: assert property (p_dir)
        else $error("wrong phase order");
    property p_cause;
        ($changed(a) || $changed(b)) |-> $past(motor_step_i);
    endproperty
    a_cause: assert property (p_cause)
        else $error("phase moved late");
    property p_pair;
        ix == index_pulse_out_second_o;
    endproperty
    a_pair: assert property (p_pair)
        else $error("index outputs differ");
    property p_width;
        $fell(ix) |-> ix_len >= INDEX_CYCLES;
    endproperty
    a_width: assert property (p_width)
        else $error("index pulse short");
    property p_spd;
        speed_monitor_out_o <= 16'sh2710 &&
            speed_monitor_out_o >= -16'sh2710;
    endproperty
    a_spd: assert property (p_spd)
        else $error("speed code out of range");
    property p_trq;
        torque_monitor_out_o <= 16'sh2710 &&
            torque_monitor_out_o >= -16'sh2710;
    endproperty
    a_trq: assert property (p_trq)
        else $error("torque code out of range");
    property p_sel;
        $stable(sel) [*6] |-> limit_data_no_o == sel;
    endproperty
    a_sel: assert property (p_sel)
        else $error("data number wrong");
endmodule
`default_nettype wire

// file: dv/semo_host_model.sv
// Host controller that counts encoder edges and index pulses.
`default_nettype none
module semo_host_model (
    input wire logic clock_i,
    input wire logic phase_a_i,
    input wire logic phase_b_i,
    input wire logic index_i,
    output int pos_o,
    output int revs_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pa = 1'h0, pb = 1'h0, pi = 1'h0;
    initial pos_o = 0;
    initial revs_o = 0;
    always @(posedge clock_i) begin
        if ({phase_a_i, phase_b_i} != {pa, pb}) begin
            pos_o <= (pa ^ phase_b_i) ? pos_o - 1 : pos_o + 1;
        end
        if (index_i && !pi) begin
            revs_o <= revs_o + 1;
        end
        pa <= phase_a_i;
        pb <= phase_b_i;
        pi <= index_i;
    end
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench of the encoder and monitor block.
`include "semo_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i, srst_i, avs_read_i, avs_write_i, motor_step_i, motor_dir_i;
    logic data_select_bit0_i, data_select_bit1_i, data_select_bit2_i;
    logic [7:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [3:0] avs_byteenable_i;
    logic avs_waitrequest_o, encoder_phase_a_out_o, encoder_phase_b_out_o;
    logic index_pulse_out_first_o, index_pulse_out_second_o;
    logic signed [15:0] detected_speed_i, detected_torque_i;
    logic signed [15:0] speed_monitor_out_o, torque_monitor_out_o;
    logic [15:0] analog_limit0_i, analog_limit1_i, speed_limit_o;
    logic [2:0] limit_data_no_o;
    int err_count = 0, checked = 0, pos, revs;
    // A 400-count turn with 100 P/R gives exactly one phase edge per step.
    semo_top #(.INDEX_CYCLES(20), .MOTOR_CPR(400)) i_dut (.*);
    semo_host_model i_host (.clock_i(clock_i),
        .phase_a_i(encoder_phase_a_out_o), .phase_b_i(encoder_phase_b_out_o),
        .index_i(index_pulse_out_first_o), .pos_o(pos), .revs_o(revs));
    task automatic give_verdict;
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(logic w, logic [7:0] adr, logic [31:0] d);
        int n = 0;
        @(posedge clock_i);
        avs_address_i <= adr;
        avs_writedata_i <= d;
        avs_read_i <= !w;
        avs_write_i <= w;
        do begin
            @(posedge clock_i);
            n++;
            if (n > 20) begin
                err_count++;
                give_verdict();
            end
        end while (avs_waitrequest_o !== 1'h0);
        rd = avs_readdata_o;
        avs_read_i <= 1'h0;
        avs_write_i <= 1'h0;
    endtask
    task automatic stat(logic [16:0] v);
        for (int k = 0; k < 20 && {rd[17], rd[15:0]} !== v; k++) begin
            bus(0, `SEMO_A_STAT, 0);
        end
        check("status", {rd[17], rd[15:0]}, v);
    endtask
    task automatic sel_all(logic an);
        for (int n = 0; n < 8; n++) begin
            @(posedge clock_i);
            {data_select_bit2_i, data_select_bit1_i,
             data_select_bit0_i} <= 3'(n);
            repeat (8) @(posedge clock_i);
            check("data no", limit_data_no_o, n);
            check("limit", speed_limit_o,
                  (an && n < 2) ? 'hA000 + n : 'h1000 + n);
        end
    endtask
    task automatic steps(logic d);
        // Steps stay sparse so one index pulse ends before the next turn.
        for (int k = 0; k < 400; k++) begin
            @(posedge clock_i);
            motor_step_i <= 1'h1;
            motor_dir_i <= d;
            @(posedge clock_i);
            motor_step_i <= 1'h0;
            repeat (2) @(posedge clock_i);
        end
        repeat (30) @(posedge clock_i);
    endtask
    task automatic mon(int s, int t, int es, int et);
        @(posedge clock_i);
        detected_speed_i <= 16'(s);
        detected_torque_i <= 16'(t);
        repeat (200) @(posedge clock_i);
        check("speed mon", 32'(speed_monitor_out_o), 32'(es));
        check("torque mon", 32'(torque_monitor_out_o), 32'(et));
    endtask
    initial begin
        clock_i = 1'h0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        {srst_i, avs_read_i, avs_write_i, motor_step_i, motor_dir_i} = 5'h10;
        {data_select_bit2_i, data_select_bit1_i, data_select_bit0_i} = 3'h0;
        {avs_address_i, avs_writedata_i, avs_byteenable_i} = 44'hF;
        {detected_speed_i, detected_torque_i} = 32'h0;
        {analog_limit0_i, analog_limit1_i} = 32'hA000_A001;
        repeat (5) @(posedge clock_i);
        srst_i <= 1'h0;
        stat(17'h1_03E8);
        bus(1, `SEMO_A_GNUM, 32'h64);
        bus(0, `SEMO_A_STAT, 0);
        check("pending", {rd[17], rd[15:0]}, 17'h1_03E8);
        bus(1, `SEMO_A_CTRL, 32'h1);
        stat(17'h1_2710);
        bus(1, `SEMO_A_GNUM, 32'h1);
        bus(1, `SEMO_A_GDEN, 32'hA);
        bus(1, `SEMO_A_SYS, 32'h0);
        bus(1, `SEMO_A_CTRL, 32'h1);
        stat(17'h0_0064);
        bus(1, 8'h30, 32'hFFFF);
        bus(0, 8'h30, 0);
        check("unmapped", rd, 32'h0);
        for (int n = 0; n < 8; n++) begin
            bus(1, 8'(`SEMO_A_DATA_BASE + 4 * n), 32'h1000 + n);
        end
        sel_all(1'h0);
        bus(1, `SEMO_A_SYS, 32'h1);
        bus(1, `SEMO_A_CTRL, 32'h1);
        stat(17'h1_0064);
        sel_all(1'h1);
        steps(1'h0);
        check("edges", pos, 400);
        check("turns", revs, 1);
        steps(1'h1);
        check("edges", pos, 0);
        check("turns", revs, 2);
        bus(1, `SEMO_A_SFS, 32'hBB8);
        bus(1, `SEMO_A_SFV, 32'hBB8);
        bus(1, `SEMO_A_TFS, 32'h96);
        bus(1, `SEMO_A_TOFS, 32'h3E8);
        mon(1500, 0, 1500, 1000);
        mon(6000, 75, 3000, 6000);
        mon(-6000, 300, -3000, 10000);
        // A single-lane write must leave the other byte of the word alone; a write to the data memory sets it to zero instead.
        avs_byteenable_i <= 4'h1;
        bus(1, `SEMO_A_SOFS, 32'h1234);
        avs_byteenable_i <= 4'hF;
        bus(0, `SEMO_A_SOFS, 0);
        check("lane", rd, 32'h34);
        give_verdict();
    end
endmodule
bind semo_top semo_chk #(.INDEX_CYCLES(INDEX_CYCLES), .MOTOR_CPR(MOTOR_CPR))
    i_chk (.*);
`default_nettype wire

// file: hdl/semo_limit_mem.sv
// Eight-word speed-limit data memory with two registered read ports.
`default_nettype none
module semo_limit_mem
    import semo_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    semo_mem_if.mem port
);
    semo_word_t data [8];
    semo_word_t next_rdata_a;
    semo_word_t next_rdata_b;

    always_comb begin
        next_rdata_a = data[port.raddr_a];
        next_rdata_b = data[port.raddr_b];
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            for (int i = 0; i < 8; i++) begin
                data[i] <= 16'h0000;
            end
            port.rdata_a <= 16'h0000;
            port.rdata_b <= 16'h0000;
        end else begin
            if (port.we) begin
                data[port.waddr] <= port.wdata;
            end
            port.rdata_a <= next_rdata_a;
            port.rdata_b <= next_rdata_b;
        end
    end
endmodule
`default_nettype wire

// file: hdl/semo_mem_if.sv
// Carrier between the block and its speed-limit data memory.
`default_nettype none
interface semo_mem_if;
    logic we;
    logic [2:0] waddr;
    logic [15:0] wdata;
    logic [2:0] raddr_a;
    logic [2:0] raddr_b;
    logic [15:0] rdata_a;
    logic [15:0] rdata_b;
    modport ctrl(output we, waddr, wdata, raddr_a, raddr_b,
                 input rdata_a, rdata_b);
    modport mem(input we, waddr, wdata, raddr_a, raddr_b,
                output rdata_a, rdata_b);
endinterface
`default_nettype wire

// file: hdl/semo_pkg.sv
// Types shared by the encoder and monitor block.
`default_nettype none
package semo_pkg;
    typedef enum logic {ST_CALC, ST_RUN} semo_state_t;
    typedef enum logic [1:0] {JOB_RES, JOB_SPD, JOB_TRQ} semo_job_t;
    typedef logic [15:0] semo_word_t;
endpackage
`default_nettype wire

// file: hdl/semo_regs.svh
// Register map, reset values and timing constants of the encoder and monitor block.
`ifndef SEMO_REGS_SVH
`define SEMO_REGS_SVH

`define SEMO_A_CTRL 8'h00
`define SEMO_A_SYS 8'h04
`define SEMO_A_GDEN 8'h08
`define SEMO_A_GNUM 8'h0C
`define SEMO_A_SFS 8'h10
`define SEMO_A_SFV 8'h14
`define SEMO_A_SOFS 8'h18
`define SEMO_A_TFS 8'h1C
`define SEMO_A_TFV 8'h20
`define SEMO_A_TOFS 8'h24
`define SEMO_A_STAT 8'h28
`define SEMO_A_LIMIT 8'h2C
`define SEMO_A_DATA_MASK 8'hE0
`define SEMO_A_DATA_BASE 8'h40

`define SEMO_CTRL_RESTART 0
`define SEMO_SYS_ANALOG 0
`define SEMO_STAT_SEL_LSB 20
`define SEMO_STAT_RUN 16
`define SEMO_STAT_ANALOG 17

`define SEMO_RST_ANALOG 1'h1
`define SEMO_RST_GEAR 16'h0001
`define SEMO_RST_SFS 16'h1770
`define SEMO_RST_TFS 16'h012C
`define SEMO_RST_FV 16'h2710
`define SEMO_RST_OFS 16'h0000

`define SEMO_RES_MUL 32'h0000_03E8
`define SEMO_RES_MIN 16'h0064
`define SEMO_RES_MAX 16'h2710
`define SEMO_RES_DEF 16'h03E8
`define SEMO_MON_LIMIT 18'h02710
`define SEMO_ANALOG_LAST_NO 3'h1
`define SEMO_DIV_STEPS 6'h20

`define SEMO_INDEX_MIN_US 400
`define SEMO_CLK_MHZ 100
`define SEMO_MOTOR_CPR_DEF 32'h0002_0000

`endif

// file: hdl/semo_top.sv
// Encoder pulse output, index outputs, analog monitor codes and limit select.
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`include "semo_regs.svh"
`default_nettype none

module semo_top
    import semo_pkg::*;
#(
    parameter int INDEX_CYCLES = `SEMO_INDEX_MIN_US * `SEMO_CLK_MHZ,
    parameter int MOTOR_CPR = `SEMO_MOTOR_CPR_DEF
) (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic motor_step_i,
    input wire logic motor_dir_i,
    input wire logic signed [15:0] detected_speed_i,
    input wire logic signed [15:0] detected_torque_i,
    input wire logic [15:0] analog_limit0_i,
    input wire logic [15:0] analog_limit1_i,
    input wire logic data_select_bit0_i,
    input wire logic data_select_bit1_i,
    input wire logic data_select_bit2_i,
    output logic encoder_phase_a_out_o,
    output logic encoder_phase_b_out_o,
    output logic index_pulse_out_first_o,
    output logic index_pulse_out_second_o,
    output logic signed [15:0] speed_monitor_out_o,
    output logic signed [15:0] torque_monitor_out_o,
    output logic [15:0] speed_limit_o,
    output logic [2:0] limit_data_no_o
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_data(input logic [7:0] a);
        return (a & `SEMO_A_DATA_MASK) == `SEMO_A_DATA_BASE;
    endfunction

    function automatic semo_word_t merge(input semo_word_t old,
                                         input logic [31:0] wd,
                                         input logic [3:0] be);
        semo_word_t r;
        r = old;
        if (be[0]) r[7:0] = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    function automatic semo_word_t magnitude(input logic signed [15:0] v,
                                             input semo_word_t fs);
        logic [16:0] m;
        m = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
        return (m > {1'b0, fs}) ? fs : m[15:0];
    endfunction

    // Offset shifts the zero point; the scaled part saturates at full volts.
    function automatic logic signed [15:0] mon_code(input logic [31:0] q,
            input semo_word_t fv, input semo_word_t ofs, input logic neg);
        logic signed [17:0] s;
        logic [15:0] qc;
        qc = (q > {16'h0000, fv}) ? fv : q[15:0];
        s = 18'($signed(ofs)) + (neg ? -$signed({2'b00, qc})
                                     : $signed({2'b00, qc}));
        if (s > $signed(`SEMO_MON_LIMIT)) s = $signed(`SEMO_MON_LIMIT);
        if (s < -$signed(`SEMO_MON_LIMIT)) s = -$signed(`SEMO_MON_LIMIT);
        return s[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    semo_mem_if mem_bus();

    semo_limit_mem u_mem (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .port(mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: fixed latency, waitrequest drops in the third cycle.
    logic [1:0] ph, next_ph;
    logic next_wait;
    logic [31:0] next_rdata;
    logic sys_pend, next_sys_pend;
    semo_word_t gden_p, next_gden_p, gnum_p, next_gnum_p;
    semo_word_t sfs, next_sfs, sfv, next_sfv, sofs, next_sofs;
    semo_word_t tfs, next_tfs, tfv, next_tfv, tofs, next_tofs;
    logic restart;
    logic wr_en;

    semo_state_t st, next_st;
    semo_word_t res;
    logic ana_act;
    logic [2:0] sel_d;

    assign wr_en = avs_write_i && !avs_waitrequest_o;
    assign mem_bus.we = wr_en && is_data(avs_address_i);
    assign mem_bus.waddr = avs_address_i[4:2];
    assign mem_bus.wdata = merge(16'h0000, avs_writedata_i,
                                 avs_byteenable_i | 4'h0);
    assign mem_bus.raddr_a = avs_address_i[4:2];
    assign restart = wr_en && (avs_address_i == `SEMO_A_CTRL)
                     && avs_byteenable_i[0]
                     && avs_writedata_i[`SEMO_CTRL_RESTART];

    always_comb begin
        next_ph = 2'h0;
        if (ph == 2'h0 && (avs_read_i || avs_write_i)) next_ph = 2'h1;
        if (ph == 2'h1) next_ph = 2'h2;
        next_wait = !(ph == 2'h1);
        next_rdata = 32'h0000_0000;
        if (is_data(avs_address_i)) begin
            next_rdata[15:0] = mem_bus.rdata_a;
        end else begin
            unique case (avs_address_i)
                `SEMO_A_SYS: next_rdata[`SEMO_SYS_ANALOG] = sys_pend;
                `SEMO_A_GDEN: next_rdata[15:0] = gden_p;
                `SEMO_A_GNUM: next_rdata[15:0] = gnum_p;
                `SEMO_A_SFS: next_rdata[15:0] = sfs;
                `SEMO_A_SFV: next_rdata[15:0] = sfv;
                `SEMO_A_SOFS: next_rdata[15:0] = sofs;
                `SEMO_A_TFS: next_rdata[15:0] = tfs;
                `SEMO_A_TFV: next_rdata[15:0] = tfv;
                `SEMO_A_TOFS: next_rdata[15:0] = tofs;
                `SEMO_A_STAT: begin
                    next_rdata[15:0] = res;
                    next_rdata[`SEMO_STAT_RUN] = (st == ST_RUN);
                    next_rdata[`SEMO_STAT_ANALOG] = ana_act;
                    next_rdata[`SEMO_STAT_SEL_LSB +: 3] = sel_d;
                end
                `SEMO_A_LIMIT: next_rdata[15:0] = speed_limit_o;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        if (ph != 2'h1) next_rdata = avs_readdata_o;
        next_sys_pend = sys_pend;
        next_gden_p = gden_p;
        next_gnum_p = gnum_p;
        next_sfs = sfs;
        next_sfv = sfv;
        next_sofs = sofs;
        next_tfs = tfs;
        next_tfv = tfv;
        next_tofs = tofs;
        if (wr_en) begin
            unique case (avs_address_i)
                `SEMO_A_SYS: if (avs_byteenable_i[0])
                    next_sys_pend = avs_writedata_i[`SEMO_SYS_ANALOG];
                `SEMO_A_GDEN: next_gden_p = merge(gden_p, avs_writedata_i,
                                                  avs_byteenable_i);
                `SEMO_A_GNUM: next_gnum_p = merge(gnum_p, avs_writedata_i,
                                                  avs_byteenable_i);
                `SEMO_A_SFS: next_sfs = merge(sfs, avs_writedata_i,
                                              avs_byteenable_i);
                `SEMO_A_SFV: next_sfv = merge(sfv, avs_writedata_i,
                                              avs_byteenable_i);
                `SEMO_A_SOFS: next_sofs = merge(sofs, avs_writedata_i,
                                                avs_byteenable_i);
                `SEMO_A_TFS: next_tfs = merge(tfs, avs_writedata_i,
                                              avs_byteenable_i);
                `SEMO_A_TFV: next_tfv = merge(tfv, avs_writedata_i,
                                              avs_byteenable_i);
                `SEMO_A_TOFS: next_tofs = merge(tofs, avs_writedata_i,
                                                avs_byteenable_i);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ph <= 2'h0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
            sys_pend <= `SEMO_RST_ANALOG;
            gden_p <= `SEMO_RST_GEAR;
            gnum_p <= `SEMO_RST_GEAR;
            sfs <= `SEMO_RST_SFS;
            sfv <= `SEMO_RST_FV;
            sofs <= `SEMO_RST_OFS;
            tfs <= `SEMO_RST_TFS;
            tfv <= `SEMO_RST_FV;
            tofs <= `SEMO_RST_OFS;
        end else begin
            ph <= next_ph;
            avs_waitrequest_o <= next_wait;
            avs_readdata_o <= next_rdata;
            sys_pend <= next_sys_pend;
            gden_p <= next_gden_p;
            gnum_p <= next_gnum_p;
            sfs <= next_sfs;
            sfv <= next_sfv;
            sofs <= next_sofs;
            tfs <= next_tfs;
            tfv <= next_tfv;
            tofs <= next_tofs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One shared serial divider serves resolution and both monitors, which
    // saves two dividers at the cost of a refresh every ~70 cycles.
    semo_job_t job, next_job;
    logic busy, next_busy, neg, next_neg, next_ana_act;
    logic [5:0] cnt, next_cnt;
    logic [31:0] dvd, next_dvd;
    semo_word_t dvs, next_dvs, next_res;
    logic [16:0] rem, next_rem, trial;
    logic signed [15:0] next_spd_mon, next_trq_mon;
    semo_word_t mag;

    always_comb begin
        next_st = st;
        next_job = job;
        next_busy = busy;
        next_neg = neg;
        next_cnt = cnt;
        next_dvd = dvd;
        next_dvs = dvs;
        next_rem = rem;
        next_res = res;
        next_ana_act = ana_act;
        next_spd_mon = speed_monitor_out_o;
        next_trq_mon = torque_monitor_out_o;
        trial = {rem[15:0], dvd[31]};
        mag = 16'h0000;
        if (restart) begin
            // Pending system settings are taken over only here.
            next_ana_act = sys_pend;
            next_st = ST_CALC;
            next_job = JOB_RES;
            next_busy = 1'b0;
        end else if (!busy) begin
            next_busy = 1'b1;
            next_cnt = `SEMO_DIV_STEPS;
            next_rem = 17'h00000;
            unique case (job)
                JOB_RES: begin
                    next_dvd = 32'(gnum_p) * `SEMO_RES_MUL;
                    next_dvs = (gden_p == 16'h0000) ? 16'h0001 : gden_p;
                    next_neg = 1'b0;
                end
                JOB_SPD: begin
                    mag = magnitude(detected_speed_i, sfs);
                    next_dvd = 32'(mag) * 32'(sfv);
                    next_dvs = sfs;
                    next_neg = detected_speed_i[15];
                end
                JOB_TRQ: begin
                    mag = magnitude(detected_torque_i, tfs);
                    next_dvd = 32'(mag) * 32'(tfv);
                    next_dvs = tfs;
                    next_neg = detected_torque_i[15];
                end
                default: next_busy = 1'b0;
            endcase
        end else if (cnt != 6'h00) begin
            next_cnt = cnt - 6'h01;
            if (trial >= {1'b0, dvs}) begin
                next_rem = trial - {1'b0, dvs};
                next_dvd = {dvd[30:0], 1'b1};
            end else begin
                next_rem = trial;
                next_dvd = {dvd[30:0], 1'b0};
            end
        end else begin
            next_busy = 1'b0;
            unique case (job)
                JOB_RES: begin
                    if (dvd < 32'(`SEMO_RES_MIN)) next_res = `SEMO_RES_MIN;
                    else if (dvd > 32'(`SEMO_RES_MAX))
                        next_res = `SEMO_RES_MAX;
                    else next_res = dvd[15:0];
                    next_st = ST_RUN;
                    next_job = JOB_SPD;
                end
                JOB_SPD: begin
                    next_spd_mon = mon_code(dvd, sfv, sofs, neg);
                    next_job = JOB_TRQ;
                end
                JOB_TRQ: begin
                    next_trq_mon = mon_code(dvd, tfv, tofs, neg);
                    next_job = JOB_SPD;
                end
                default: next_job = JOB_RES;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            st <= ST_CALC;
            job <= JOB_RES;
            busy <= 1'b0;
            neg <= 1'b0;
            cnt <= 6'h00;
            dvd <= 32'h0000_0000;
            dvs <= 16'h0001;
            rem <= 17'h00000;
            res <= `SEMO_RES_DEF;
            ana_act <= `SEMO_RST_ANALOG;
            speed_monitor_out_o <= 16'h0000;
            torque_monitor_out_o <= 16'h0000;
        end else begin
            st <= next_st;
            job <= next_job;
            busy <= next_busy;
            neg <= next_neg;
            cnt <= next_cnt;
            dvd <= next_dvd;
            dvs <= next_dvs;
            rem <= next_rem;
            res <= next_res;
            ana_act <= next_ana_act;
            speed_monitor_out_o <= next_spd_mon;
            torque_monitor_out_o <= next_trq_mon;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Encoder: each motor count adds (forward) or subtracts (reverse) 4*res on a phase accumulator modulo
    // the motor counts per turn; each wrap is one quadrature edge. The host
    // must keep the phase rate under 1 MHz if it uses the index pulses.
    logic [17:0] acc, next_acc, pos, next_pos, inc, sum;
    logic [1:0] qc, next_qc;
    logic [23:0] idx_cnt, next_idx_cnt;
    logic next_a, next_b, next_idx;

    always_comb begin
        next_acc = acc;
        next_pos = pos;
        next_qc = qc;
        next_idx_cnt = (idx_cnt != 24'h000000) ? idx_cnt - 24'h000001
                                               : idx_cnt;
        inc = {res, 2'b00};
        sum = acc + inc;
        // Counts run in every control mode; only the resolution calculation (ST_CALC) after reset or restart holds them.
        if (st == ST_RUN && motor_step_i) begin
            if (!motor_dir_i) begin
                if (sum >= 18'(MOTOR_CPR)) begin
                    next_acc = sum - 18'(MOTOR_CPR);
                    next_qc = qc + 2'h1;
                end else begin
                    next_acc = sum;
                end
                next_pos = (pos == 18'(MOTOR_CPR - 1)) ? 18'h00000
                                                        : pos + 18'h00001;
                if (pos == 18'(MOTOR_CPR - 1))
                    next_idx_cnt = 24'(INDEX_CYCLES);
            end else begin
                if (acc >= inc) begin
                    next_acc = acc - inc;
                end else begin
                    next_acc = acc + 18'(MOTOR_CPR) - inc;
                    next_qc = qc - 2'h1;
                end
                next_pos = (pos == 18'h00000) ? 18'(MOTOR_CPR - 1)
                                              : pos - 18'h00001;
                if (pos == 18'h00000)
                    next_idx_cnt = 24'(INDEX_CYCLES);
            end
        end
        // Gray sequence 00,10,11,01 on (A,B): B trails A by a quarter.
        next_a = next_qc[1] ^ next_qc[0];
        next_b = next_qc[1];
        next_idx = next_idx_cnt != 24'h000000;
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            acc <= 18'h00000;
            pos <= 18'h00000;
            qc <= 2'h0;
            idx_cnt <= 24'h000000;
            encoder_phase_a_out_o <= 1'b0;
            encoder_phase_b_out_o <= 1'b0;
            index_pulse_out_first_o <= 1'b0;
            index_pulse_out_second_o <= 1'b0;
        end else begin
            acc <= next_acc;
            pos <= next_pos;
            qc <= next_qc;
            idx_cnt <= next_idx_cnt;
            encoder_phase_a_out_o <= next_a;
            encoder_phase_b_out_o <= next_b;
            index_pulse_out_first_o <= next_idx;
            index_pulse_out_second_o <= next_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed-limit select from the synchronised select pins.
    logic [2:0] sel_s1, sel_s2;
    logic [15:0] next_limit;

    assign mem_bus.raddr_b = sel_s2;

    always_comb begin
        next_limit = mem_bus.rdata_b;
        if (ana_act && sel_d <= `SEMO_ANALOG_LAST_NO) begin
            next_limit = (sel_d == 3'h0) ? analog_limit0_i : analog_limit1_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sel_s1 <= 3'h0;
            sel_s2 <= 3'h0;
            sel_d <= 3'h0;
            speed_limit_o <= 16'h0000;
            limit_data_no_o <= 3'h0;
        end else begin
            sel_s1 <= {data_select_bit2_i, data_select_bit1_i,
                       data_select_bit0_i};
            sel_s2 <= sel_s1;
            sel_d <= sel_s2;
            speed_limit_o <= next_limit;
            limit_data_no_o <= sel_d;
        end
    end
endmodule
`default_nettype wire
